// File: wtbm_pkg.sv
// Package with register map, field layouts and timing constants of the wake timer block.
package wtbm_pkg;
   localparam logic [6:0] ADDR_WAKE_EXP   = 7'h14;
   localparam logic [6:0] ADDR_WAKE_MANT_H = 7'h15;
   localparam logic [6:0] ADDR_WAKE_MANT_L = 7'h16;
   localparam logic [6:0] ADDR_WAKE_CNT_H = 7'h17;
   localparam logic [6:0] ADDR_WAKE_CNT_L = 7'h18;
   localparam logic [6:0] ADDR_BAT_THR    = 7'h1a;
   localparam logic [6:0] ADDR_BAT_LEVEL  = 7'h1b;
   localparam logic [4:0] RST_WAKE_EXP    = 5'h03;
   localparam logic [7:0] RST_WAKE_MANT   = 8'h00;
   localparam logic [4:0] RST_BAT_THR     = 5'h14;
   localparam int         EXP_W           = 5;
   localparam int         BAT_W           = 5;
   localparam int         LOW_RUN_NEEDED  = 4;
   localparam int         PRESCALE_W      = 2;
   localparam int         BAT_PERIOD_MS   = 1000;
   localparam int         BAT_ON_US       = 250;
   localparam int         SLOW_HZ         = 32768;
   localparam int         BAT_PERIOD_TICKS = SLOW_HZ * BAT_PERIOD_MS / 1000;
   localparam int         BAT_ON_TICKS    = (SLOW_HZ * BAT_ON_US + 999_999) / 1_000_000;
   typedef enum logic [1:0] {
      WTBM_ACTIVE = 2'b00,
      WTBM_SLEEP  = 2'b01,
      WTBM_WAKE   = 2'b10
   } wtbm_state_t;
endpackage

// File: wtbm_core.sv
// Wake timer and battery detector of the transceiver, with their registers.
`timescale 1ns/10ps
// Function
// - Wake timer uses RC clock unless crystal selected.
// - In sleep with timer enabled, count period.
// - Period is four times M times two-to-R ticks.
// - Expiry asserts (pulls low) interrupt line when interrupt enabled.
// - Current 16-bit count readable at any time.
// - Enabled expiry drives line low, wakes crystal.
// - Disabled interrupt: stay in state, pulse GPIO.
// - Crystal select moves first GPIO to crystal.
// - Five-bit battery threshold, resets to 14h.
// - Battery level readable, upper bits zero.
// - Level code is 1.7 V plus 50 mV steps.
// - Below-threshold level asserts enabled battery interrupt.
// - Detector measures every second for 250 us.
// - Four consecutive low readings before interrupt.
// - Detector starts RC oscillator unless crystal selected.
// - Pending interrupt keeps MCU clock, delays mode.
module wtbm_core #(
   parameter int BAT_PERIOD = wtbm_pkg::BAT_PERIOD_TICKS,
   parameter int BAT_ON     = wtbm_pkg::BAT_ON_TICKS
) (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       rc_tick_i,
   input  wire logic       xtal_tick_i,
   input  wire logic       ext_crystal_select_i,
   input  wire logic       sleep_cmd_i,
   input  wire logic       wake_timer_en_i,
   input  wire logic       battery_detector_en_i,
   input  wire logic       wake_irq_en_i,
   input  wire logic       bat_irq_en_i,
   input  wire logic       status_read_i,
   input  wire logic [4:0] bat_adc_code_i,
   input  wire logic       bat_adc_valid_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [6:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   output logic            interrupt_request_line_n_o,
   output logic            wake_irq_flag_o,
   output logic            bat_irq_flag_o,
   output logic            wake_gpio_pulse_o,
   output logic            gpio0_is_crystal_o,
   output logic            rc_osc_on_o,
   output logic            bat_power_o,
   output logic            main_xtal_on_o,
   output logic            mcu_clk_en_o,
   output logic            chip_sleeping_o
);
   localparam int PW   = 24;
   localparam int CW   = 16;
   // Four times two-to-31 needs 34 bits, so the prescaler is that wide.
   localparam int PREW = 34;

   initial begin
      if (BAT_ON < 1) begin
         $error("wtbm_core: measurement window must be at least one tick");
      end
      if (BAT_PERIOD <= BAT_ON) begin
         $error("wtbm_core: measurement period must exceed the window");
      end
      if (BAT_PERIOD >= (1 << PW)) begin
         $error("wtbm_core: measurement period too long for its counter");
      end
   end

   logic [4:0]             exp_ff;
   logic [15:0]            mant_ff;
   logic [4:0]             thr_ff;
   logic [4:0]             level_ff;
   logic [CW-1:0]          count_ff;
   logic [PREW-1:0]        pre_ff;
   logic [PW-1:0]          bat_tick_ff;
   logic [2:0]             low_run_ff;
   logic                   wake_flag_ff;
   logic                   bat_flag_ff;
   logic                   gpio_pulse_ff;
   logic                   rdata_sel_ff;
   logic [7:0]             rdata_ff;
   logic                   irq_n_ff;
   logic                   bat_pwr_ff;
   logic                   rc_on_ff;
   logic                   xtal_ff;
   logic                   mclk_ff;
   logic                   sleep_ff;
   logic                   gpio0_ff;
   wtbm_pkg::wtbm_state_t  state_ff;
   wtbm_pkg::wtbm_state_t  nxt_state;

   logic       slow_tick;
   logic       wake_run;
   logic       pre_done;
   logic       expiry;
   logic       bat_sample;
   logic       pending;
   logic       bat_low_event;
   logic [PREW-1:0] pre_limit;

   // Prescale limit: four times two-to-R slow ticks per count step.
   function automatic logic [PREW-1:0] prescale_limit(input logic [4:0] r);
      logic [PREW-1:0] v;
      v = 34'h0_0000_0004 << r;
      return v - 34'h0_0000_0001;
   endfunction

   function automatic logic level_lt(input logic [4:0] code);
      return code < thr_ff;
   endfunction

   assign slow_tick  = ext_crystal_select_i ? xtal_tick_i : rc_tick_i;
   assign wake_run   = (state_ff == wtbm_pkg::WTBM_SLEEP) && wake_timer_en_i;
   assign pre_limit  = prescale_limit(exp_ff);
   assign pre_done   = slow_tick && (pre_ff >= pre_limit);
   assign expiry     = wake_run && pre_done && (count_ff + 16'h0001 >= mant_ff);
   assign bat_sample = bat_adc_valid_i && bat_pwr_ff;
   assign pending    = wake_flag_ff || bat_flag_ff;
   assign bat_low_event = bat_sample && bat_irq_en_i && level_lt(bat_adc_code_i) &&
                          (low_run_ff == 3'(wtbm_pkg::LOW_RUN_NEEDED - 1));

   // Register writes.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         exp_ff  <= wtbm_pkg::RST_WAKE_EXP;
         mant_ff <= {wtbm_pkg::RST_WAKE_MANT, wtbm_pkg::RST_WAKE_MANT};
         thr_ff  <= wtbm_pkg::RST_BAT_THR;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            wtbm_pkg::ADDR_WAKE_EXP:    exp_ff       <= reg_wdata_i[4:0];
            wtbm_pkg::ADDR_WAKE_MANT_H: mant_ff[15:8] <= reg_wdata_i;
            wtbm_pkg::ADDR_WAKE_MANT_L: mant_ff[7:0]  <= reg_wdata_i;
            wtbm_pkg::ADDR_BAT_THR:     thr_ff       <= reg_wdata_i[4:0];
            default: ;
         endcase
      end
   end

   // Register reads, registered one cycle after the strobe.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            wtbm_pkg::ADDR_WAKE_EXP:    rdata_ff <= {3'b000, exp_ff};
            wtbm_pkg::ADDR_WAKE_MANT_H: rdata_ff <= mant_ff[15:8];
            wtbm_pkg::ADDR_WAKE_MANT_L: rdata_ff <= mant_ff[7:0];
            wtbm_pkg::ADDR_WAKE_CNT_H:  rdata_ff <= count_ff[15:8];
            wtbm_pkg::ADDR_WAKE_CNT_L:  rdata_ff <= count_ff[7:0];
            wtbm_pkg::ADDR_BAT_THR:     rdata_ff <= {3'b000, thr_ff};
            wtbm_pkg::ADDR_BAT_LEVEL:   rdata_ff <= {3'b000, level_ff};
            default:                    rdata_ff <= 8'h00;
         endcase
      end
   end

   // Wake timer prescaler and count; reloads at expiry.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_ff   <= '0;
         count_ff <= 16'h0000;
      end else if (!wake_run) begin
         pre_ff   <= '0;
         count_ff <= 16'h0000;
      end else if (slow_tick) begin
         if (pre_done) begin
            pre_ff   <= '0;
            count_ff <= expiry ? 16'h0000 : count_ff + 16'h0001;
         end else begin
            pre_ff <= pre_ff + 34'h0_0000_0001;
         end
      end
   end

   // Wake flag: set wins over the status-read clear.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wake_flag_ff <= 1'b0;
      end else if (expiry && wake_irq_en_i) begin
         wake_flag_ff <= 1'b1;
      end else if (status_read_i) begin
         wake_flag_ff <= 1'b0;
      end
   end

   // Battery flag: set wins over the status-read clear.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bat_flag_ff <= 1'b0;
      end else if (bat_low_event) begin
         bat_flag_ff <= 1'b1;
      end else if (status_read_i) begin
         bat_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_n_ff <= 1'b1;
      end else begin
         irq_n_ff <= !(pending || (expiry && wake_irq_en_i));
      end
   end

   // Without the wake interrupt an expiry only pulses the GPIO output.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gpio_pulse_ff <= 1'b0;
      end else begin
         gpio_pulse_ff <= expiry && !wake_irq_en_i;
      end
   end

   // Battery detector: one measurement window each period.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bat_tick_ff <= '0;
      end else if (!battery_detector_en_i) begin
         bat_tick_ff <= '0;
      end else if (slow_tick) begin
         bat_tick_ff <= (bat_tick_ff >= PW'(BAT_PERIOD - 1)) ? '0 : bat_tick_ff + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bat_pwr_ff <= 1'b0;
      end else if (!battery_detector_en_i) begin
         bat_pwr_ff <= 1'b0;
      end else if (slow_tick) begin
         bat_pwr_ff <= (bat_tick_ff < PW'(BAT_ON - 1)) ||
                       (bat_tick_ff >= PW'(BAT_PERIOD - 1));
      end
   end

   // The last level stays readable after the detector is switched off.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_ff <= 5'h00;
      end else if (battery_detector_en_i && bat_sample) begin
         level_ff <= bat_adc_code_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_run_ff <= 3'b000;
      end else if (!battery_detector_en_i) begin
         low_run_ff <= 3'b000;
      end else if (bat_sample) begin
         if (!level_lt(bat_adc_code_i)) begin
            low_run_ff <= 3'b000;
         end else if (low_run_ff < 3'(wtbm_pkg::LOW_RUN_NEEDED)) begin
            low_run_ff <= low_run_ff + 3'b001;
         end
      end
   end

   // Power state: pending interrupts hold the crystal and MCU clock.
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         wtbm_pkg::WTBM_ACTIVE: if (sleep_cmd_i && !pending) nxt_state = wtbm_pkg::WTBM_SLEEP;
         wtbm_pkg::WTBM_SLEEP: begin
            if (expiry && wake_irq_en_i) nxt_state = wtbm_pkg::WTBM_WAKE;
            else if (!sleep_cmd_i) nxt_state = wtbm_pkg::WTBM_ACTIVE;
         end
         wtbm_pkg::WTBM_WAKE: if (!pending) begin
            nxt_state = sleep_cmd_i ? wtbm_pkg::WTBM_SLEEP : wtbm_pkg::WTBM_ACTIVE;
         end
         default: nxt_state = wtbm_pkg::WTBM_ACTIVE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= wtbm_pkg::WTBM_ACTIVE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // A pending interrupt keeps the main crystal up even while asleep.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         xtal_ff <= 1'b1;
      end else begin
         xtal_ff <= (nxt_state != wtbm_pkg::WTBM_SLEEP) || pending;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mclk_ff <= 1'b1;
      end else begin
         mclk_ff <= (nxt_state != wtbm_pkg::WTBM_SLEEP) || pending;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sleep_ff <= 1'b0;
      end else begin
         sleep_ff <= (nxt_state == wtbm_pkg::WTBM_SLEEP);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rc_on_ff <= 1'b0;
      end else begin
         rc_on_ff <= !ext_crystal_select_i && (battery_detector_en_i || wake_timer_en_i);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gpio0_ff <= 1'b0;
      end else begin
         gpio0_ff <= ext_crystal_select_i;
      end
   end

   assign reg_rdata_o                = rdata_ff;
   assign interrupt_request_line_n_o = irq_n_ff;
   assign wake_irq_flag_o            = wake_flag_ff;
   assign bat_irq_flag_o             = bat_flag_ff;
   assign wake_gpio_pulse_o          = gpio_pulse_ff;
   assign gpio0_is_crystal_o         = gpio0_ff;
   assign rc_osc_on_o                = rc_on_ff;
   assign bat_power_o                = bat_pwr_ff;
   assign main_xtal_on_o             = xtal_ff;
   assign mcu_clk_en_o               = mclk_ff;
   assign chip_sleeping_o            = sleep_ff;
endmodule // wtbm_core

// File: wtbm_core_assertions.sv
// Checker with the port-level properties of the wake timer and battery detector.
`timescale 1ns/10ps
module wtbm_chk (
   input wire logic       clk_i, rst_n_i, rc_tick_i, xtal_tick_i, ext_crystal_select_i,
   input wire logic       battery_detector_en_i, wake_irq_en_i, status_read_i,
   input wire logic       bat_adc_valid_i, reg_rd_i,
   input wire logic [6:0] reg_addr_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       interrupt_request_line_n_o, wake_irq_flag_o, bat_irq_flag_o,
   input wire logic       wake_gpio_pulse_o, gpio0_is_crystal_o, rc_osc_on_o,
   input wire logic       main_xtal_on_o, mcu_clk_en_o, chip_sleeping_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_pin_to_crystal: assert property ($rose(ext_crystal_select_i) |-> ##[0:2] gpio0_is_crystal_o)
      else $error("crystal pin not reassigned");
   a_level_upper_zero: assert property (reg_rd_i && reg_addr_i == wtbm_pkg::ADDR_BAT_LEVEL
      |=> reg_rdata_o[7:5] == 3'h0) else $error("level upper bits set");
   a_thr_upper_zero: assert property (reg_rd_i && reg_addr_i == wtbm_pkg::ADDR_BAT_THR
      |=> reg_rdata_o[7:5] == 3'h0) else $error("threshold upper bits set");
   a_irq_has_cause: assert property (!interrupt_request_line_n_o |-> wake_irq_flag_o ||
      bat_irq_flag_o || $past(wake_irq_flag_o) || $past(bat_irq_flag_o)) else $error("stray irq");
   a_irq_keeps_clock: assert property (!interrupt_request_line_n_o && !$past(interrupt_request_line_n_o)
      |-> mcu_clk_en_o && main_xtal_on_o) else $error("clock dropped while irq pending");
   a_read_clears_irq: assert property (status_read_i && !(rc_tick_i || xtal_tick_i || bat_adc_valid_i)
      |=> !wake_irq_flag_o && !bat_irq_flag_o ##1 (interrupt_request_line_n_o ||
      $past(rc_tick_i || xtal_tick_i || bat_adc_valid_i))) else $error("irq not released by status read");
   a_gpio_pulse_single: assert property (wake_gpio_pulse_o |-> !$past(wake_irq_en_i)
      ##1 !wake_gpio_pulse_o) else $error("bad expiry pulse");
   a_rc_for_battery: assert property ((chip_sleeping_o && battery_detector_en_i)[*3]
      |-> rc_osc_on_o) else $error("rc oscillator off for detector");
   a_wake_from_sleep: assert property ($rose(wake_irq_flag_o) |-> $past(chip_sleeping_o) ||
      $past(chip_sleeping_o, 2)) else $error("wake event outside sleep");
   c_wake_irq: cover property ($fell(interrupt_request_line_n_o) && wake_irq_flag_o);
   c_gpio_pulse: cover property (wake_gpio_pulse_o);
   c_bat_irq: cover property (bat_irq_flag_o && !interrupt_request_line_n_o);
endmodule // wtbm_chk

bind wtbm_core wtbm_chk u_chk (.clk_i, .rst_n_i, .rc_tick_i, .xtal_tick_i, .ext_crystal_select_i,
   .battery_detector_en_i, .wake_irq_en_i, .status_read_i, .bat_adc_valid_i, .reg_rd_i,
   .reg_addr_i, .reg_rdata_o, .interrupt_request_line_n_o, .wake_irq_flag_o, .bat_irq_flag_o,
   .wake_gpio_pulse_o, .gpio0_is_crystal_o, .rc_osc_on_o, .main_xtal_on_o, .mcu_clk_en_o,
   .chip_sleeping_o);

// File: wtbm_env_model.sv
// Model of the slow clock sources and the battery converter around the block.
`timescale 1ns/10ps
module wtbm_env_model #(
   parameter int RC_DIV = 10,
   parameter int XT_DIV = 13
) (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       rc_run_i,
   input  wire logic       bat_power_i,
   input  wire logic [4:0] level_i,
   output logic            rc_tick_o,
   output logic            xtal_tick_o,
   output logic            adc_valid_o,
   output logic      [4:0] adc_code_o
);
   int   rc_cnt_ff, xt_cnt_ff;
   logic pow_ff;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {rc_cnt_ff, xt_cnt_ff, rc_tick_o, xtal_tick_o, pow_ff, adc_valid_o} <= '0;
         adc_code_o <= 5'h00;
      end else begin
         rc_cnt_ff <= (rc_cnt_ff >= RC_DIV - 1) ? 0 : rc_cnt_ff + 1;
         xt_cnt_ff <= (xt_cnt_ff >= XT_DIV - 1) ? 0 : xt_cnt_ff + 1;
         rc_tick_o <= rc_run_i && rc_cnt_ff == 0;
         xtal_tick_o <= xt_cnt_ff == 0;
         pow_ff <= bat_power_i;
         adc_valid_o <= bat_power_i && !pow_ff;
         // An unpowered converter does not hold its last code.
         adc_code_o <= bat_power_i ? level_i : ~adc_code_o;
      end
   end
endmodule // wtbm_env_model

// File: wtbm_core_tb.sv
// Self-checking testbench of the wake timer and battery detector.
`timescale 1ns/10ps
`define CHK(s, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
   $display("Error %s expected %h seen %h", s, e, g); end end
module wtbm_core_tb;
   logic       clk_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic       rc_tick_i, xtal_tick_i, ext_crystal_select_i, sleep_cmd_i, wake_timer_en_i;
   logic       battery_detector_en_i, wake_irq_en_i, bat_irq_en_i, status_read_i;
   logic       bat_adc_valid_i, reg_wr_i, reg_rd_i, rc_run, interrupt_request_line_n_o;
   logic       wake_irq_flag_o, bat_irq_flag_o, wake_gpio_pulse_o, gpio0_is_crystal_o;
   logic       rc_osc_on_o, bat_power_o, main_xtal_on_o, mcu_clk_en_o, chip_sleeping_o;
   logic [4:0] bat_adc_code_i, level;
   logic [6:0] reg_addr_i;
   logic [7:0] reg_wdata_i, reg_rdata_o;
   int         n_fail = 0, samples_checked = 0, n = 0, n_pulse = 0, n_adc = 0, p0 = 0, a0 = 0;

   wtbm_core #(.BAT_PERIOD(40), .BAT_ON(2)) DUT (.clk_i, .rst_n_i, .rc_tick_i, .xtal_tick_i,
      .ext_crystal_select_i, .sleep_cmd_i, .wake_timer_en_i, .battery_detector_en_i,
      .wake_irq_en_i, .bat_irq_en_i, .status_read_i, .bat_adc_code_i, .bat_adc_valid_i,
      .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .interrupt_request_line_n_o,
      .wake_irq_flag_o, .bat_irq_flag_o, .wake_gpio_pulse_o, .gpio0_is_crystal_o, .rc_osc_on_o,
      .bat_power_o, .main_xtal_on_o, .mcu_clk_en_o, .chip_sleeping_o);
   wtbm_env_model u_env (.clk_i(clk_i), .rst_n_i(rst_n_i), .rc_run_i(rc_run),
      .bat_power_i(bat_power_o), .level_i(level), .rc_tick_o(rc_tick_i),
      .xtal_tick_o(xtal_tick_i), .adc_valid_o(bat_adc_valid_i), .adc_code_o(bat_adc_code_i));

   initial begin
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      n_pulse <= n_pulse + int'(wake_gpio_pulse_o === 1'b1);
      n_adc <= n_adc + int'(bat_adc_valid_i === 1'b1);
   end

   task automatic complete_run();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_i) #1;
      {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
      @(posedge clk_i) #1;
      reg_wr_i = 1'b0;
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input string s);
      @(posedge clk_i) #1;
      {reg_addr_i, reg_rd_i} = {a, 1'b1};
      @(posedge clk_i) #1;
      reg_rd_i = 1'b0;
      `CHK(s, e, reg_rdata_o)
   endtask
   task automatic wait_irq(input int lim);
      n = 0;
      while (interrupt_request_line_n_o !== 1'b0 && n < lim) begin
         @(posedge clk_i) #1;
         n++;
      end
      if (n >= lim) begin
         n_fail++;
         complete_run();
      end
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge clk_i);
      #1;
   endtask

   initial begin
      {ext_crystal_select_i, sleep_cmd_i, wake_timer_en_i, battery_detector_en_i} = 4'h0;
      {wake_irq_en_i, bat_irq_en_i, status_read_i, reg_wr_i, reg_rd_i, rc_run} = 6'h01;
      {reg_addr_i, reg_wdata_i, level} = '0;
      idle(8);
      rst_n_i = 1'b1;
      rd_chk(wtbm_pkg::ADDR_WAKE_EXP, 8'h03, "exp reset");
      rd_chk(wtbm_pkg::ADDR_WAKE_MANT_H, 8'h00, "mant reset");
      rd_chk(wtbm_pkg::ADDR_BAT_THR, 8'h14, "thr reset");
      rd_chk(7'h00, 8'h00, "unmapped");
      wr_reg(wtbm_pkg::ADDR_BAT_THR, 8'hff);
      rd_chk(wtbm_pkg::ADDR_BAT_THR, 8'h1f, "thr width");
      wr_reg(wtbm_pkg::ADDR_BAT_THR, 8'h0a);
      wr_reg(wtbm_pkg::ADDR_WAKE_EXP, 8'h00);
      wr_reg(wtbm_pkg::ADDR_WAKE_MANT_L, 8'h02);
      rd_chk(wtbm_pkg::ADDR_WAKE_MANT_L, 8'h02, "mant low");
      {wake_timer_en_i, wake_irq_en_i, sleep_cmd_i} = 3'b111;
      // Eight slow ticks of ten clocks each, plus tick phase and flag latency.
      wait_irq(200);
      `CHK("wake period", 1'b1, n >= 68 && n <= 95)
      `CHK("wake flag", 1'b1, wake_irq_flag_o)
      `CHK("main xtal", 1'b1, main_xtal_on_o)
      `CHK("mcu clock", 1'b1, mcu_clk_en_o)
      rd_chk(wtbm_pkg::ADDR_WAKE_CNT_H, 8'h00, "count high");
      sleep_cmd_i = 1'b0;
      @(posedge clk_i) #1;
      status_read_i = 1'b1;
      idle(1);
      status_read_i = 1'b0;
      idle(2);
      `CHK("irq released", 1'b1, interrupt_request_line_n_o)
      {wake_irq_en_i, sleep_cmd_i} = 2'b01;
      p0 = n_pulse;
      idle(260);
      `CHK("periodic pulses", 1'b1, n_pulse - p0 >= 3)
      `CHK("no irq", 1'b1, interrupt_request_line_n_o)
      `CHK("stays asleep", 1'b1, chip_sleeping_o)
      {rc_run, ext_crystal_select_i} = 2'b01;
      p0 = n_pulse;
      idle(250);
      `CHK("gpio0 crystal", 1'b1, gpio0_is_crystal_o)
      `CHK("crystal ticks", 1'b1, n_pulse - p0 >= 2)
      ext_crystal_select_i = 1'b0;
      p0 = n_pulse;
      idle(250);
      `CHK("rc source", 0, n_pulse - p0)
      {wake_timer_en_i, rc_run, level} = {2'b01, 5'h05};
      {battery_detector_en_i, bat_irq_en_i} = 2'b11;
      a0 = n_adc;
      idle(3);
      `CHK("rc on", 1'b1, rc_osc_on_o)
      wait_irq(2200);
      `CHK("four samples", 4, n_adc - a0)
      `CHK("battery flag", 1'b1, bat_irq_flag_o)
      `CHK("battery power", 1'b1, bat_power_o)
      rd_chk(wtbm_pkg::ADDR_BAT_LEVEL, 8'h05, "level");
      `CHK("xtal held", 1'b1, main_xtal_on_o)
      complete_run();
   end
endmodule // wtbm_core_tb
